// ===== mat_pkg.sv
// Overview of operation
// - code fetch lasts code_wait_field plus one clocks, for settings 4 to 7
// - code wait applies to fetches and table reads; code writes use data strobe
// - a code read cycle lasts between 5 and 8 clocks
// - code writes via external move take at least 4 wait states
// - both pointer extensions and the indirect extension reset to zero
// - pointer moves take address bits 23:16 from that pointer's extension
// - indirect moves use indirect extension, port 2 and the index register
// - select bit 0 picks pointer 0 or pointer 1
// - with toggle enabled, pointer instructions other than jumps invert the select bit
// - decrement bits choose increment or decrement per pointer
// - selected pointer serves pointer moves, table reads, jumps, increments, loads
// - data strobe lasts field plus one clocks for settings 2 to 7
// - data strobe field resets to 7, new value used on next moves
// - internal wait register resets to all ones, RAM, network, flash
// - internal RAM access lasts RAM field plus two clocks
// - network and flash accesses last their field plus three clocks
// - latch strobe stays high duration register plus one clocks
// - latch duration register is 8 bits and resets to 0xFF
// - latch strobe driven only in multiplexed pin modes 001 and 011
// - external writes go to code memory only when program write enabled
package mat_pkg;

    // ----
    // register offsets
    // ----
    localparam logic [7:0] OFF_PTR0_LO = 8'h82;
    localparam logic [7:0] OFF_PTR0_HI = 8'h83;
    localparam logic [7:0] OFF_PTR1_LO = 8'h84;
    localparam logic [7:0] OFF_PTR1_HI = 8'h85;
    localparam logic [7:0] OFF_PTR_SEL = 8'h86;
    localparam logic [7:0] OFF_STROBE_CTL = 8'h8E;
    localparam logic [7:0] OFF_CODE_WAIT = 8'h92;
    localparam logic [7:0] OFF_PTR0_EXT = 8'h93;
    localparam logic [7:0] OFF_PTR1_EXT = 8'h95;
    localparam logic [7:0] OFF_INT_WAIT = 8'h9C;
    localparam logic [7:0] OFF_LATCH_DUR = 8'h9F;
    localparam logic [7:0] OFF_IND_EXT = 8'hEA;

    // ----
    // reset values
    // ----
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [7:0] RST_PTR_SEL = 8'h00;
    localparam logic [7:0] RST_STROBE_CTL = 8'h07;
    localparam logic [2:0] RST_CODE_WAIT = 3'h7;
    localparam logic [7:0] RST_EXT = 8'h00;
    localparam logic [7:0] RST_INT_WAIT = 8'hFF;
    localparam logic [7:0] RST_LATCH_DUR = 8'hFF;

    // ----
    // field positions
    // ----
    localparam int SEL_BIT = 0;
    localparam int TOGGLE_BIT = 5;
    localparam int DEC0_BIT = 6;
    localparam int DEC1_BIT = 7;
    localparam int RAM_WAIT_LSB = 6;
    localparam int NET_WAIT_LSB = 3;
    localparam int FLASH_WAIT_LSB = 0;

    // ----
    // cycle counts
    // ----
    localparam logic [2:0] CODE_WAIT_MIN = 3'h4;
    localparam logic [2:0] DATA_STROBE_MIN = 3'h2;
    localparam logic [2:0] CODE_WR_WAIT_MIN = 3'h4;
    localparam logic [3:0] RAM_EXTRA = 4'h2;
    localparam logic [3:0] PERIPH_EXTRA = 4'h3;

    // multiplexed pin modes
    localparam logic [2:0] PIN_MODE_MUX1 = 3'h1;
    localparam logic [2:0] PIN_MODE_MUX2 = 3'h3;

    // ----
    // core operations
    // ----
    typedef enum logic [3:0] {
        OP_FETCH = 4'h0,
        OP_PTR_INC = 4'h1,
        OP_PTR_LOAD = 4'h2,
        OP_TABLE_RD = 4'h3,
        OP_JUMP = 4'h4,
        OP_MOVE_PTR_RD = 4'h5,
        OP_MOVE_PTR_WR = 4'h6,
        OP_MOVE_IND_RD = 4'h7,
        OP_MOVE_IND_WR = 4'h8
    } mat_op_t;

    // internal memory targets
    typedef enum logic [1:0] {
        TGT_RAM = 2'h0,
        TGT_NET = 2'h1,
        TGT_FLASH = 2'h2
    } mat_tgt_t;

    // access sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LATCH = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_DONE = 4'b1000
    } mat_state_t;

endpackage

// ===== mat_wait_timer.sv
`timescale 1ns/1ps
// ----
// cycle timer: run stays high for exactly len cycles after start
// ----
module mat_wait_timer #(
    parameter int W = 9
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // control
    input wire logic start_i,
    input wire logic [W-1:0] len_i,
    // status
    output logic run_o,
    output logic last_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } mwt_state_t;

    mwt_state_t st;
    mwt_state_t next_st;

    // a restart simply reloads, so back to back phases need no gap
    always_comb begin
        next_st = st;
        if (start_i) begin
            next_st.cnt = len_i;
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign run_o = (st.cnt != '0);
    assign last_o = (st.cnt == W'(1));

endmodule

// ===== mat_ptr_step.sv
`timescale 1ns/1ps
// ----
// pointer step: one increment or decrement of a 16-bit pointer
// ----
module mat_ptr_step (
    // operand
    input wire logic [15:0] ptr_i,
    input wire logic dec_i,
    // result
    output logic [15:0] ptr_o
);

    // wraps silently at both ends, as the core expects
    assign ptr_o = dec_i ? ptr_i - 16'h0001 : ptr_i + 16'h0001;

endmodule

// ===== mat_sfr_timing.sv
`timescale 1ns/1ps
module mat_sfr_timing (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic sfr_hit_o,
    // operation request from the instruction sequencer
    input wire logic op_valid_i,
    input wire mat_pkg::mat_op_t op_code_i,
    input wire logic [15:0] op_addr_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] index_i,
    input wire logic [7:0] port2_i,
    input wire logic program_write_enable_bit_i,
    input wire logic [2:0] external_pin_mode_i,
    output logic op_busy_o,
    output logic op_done_o,
    output logic [15:0] jump_addr_o,
    // memory side
    output logic [23:0] mem_addr_o,
    output logic code_rd_o,
    output logic code_wr_o,
    output logic data_rd_o,
    output logic data_wr_o,
    output logic latch_strobe_o,
    // internal memory access
    input wire logic int_req_i,
    input wire mat_pkg::mat_tgt_t int_tgt_i,
    output logic int_busy_o,
    output logic int_done_o
);
    import mat_pkg::*;

    // ----
    // state
    // ----
    typedef struct packed {
        logic [15:0] pointer0_pair;
        logic [15:0] pointer1_pair;
        logic pointer1_decrement_bit;
        logic pointer0_decrement_bit;
        logic toggle_enable_bit;
        logic select_bit;
        logic [1:0] strobe_ctl_upper;
        logic [2:0] data_strobe_field;
        logic [2:0] code_wait_field;
        logic [7:0] pointer0_extension;
        logic [7:0] pointer1_extension;
        logic [7:0] internal_wait_states;
        logic [7:0] latch_strobe_duration;
        logic [7:0] indirect_move_extension;
        mat_state_t seq;
        logic [3:0] width;
        logic to_code;
        logic is_write;
        logic [23:0] addr;
        logic code_rd;
        logic code_wr;
        logic data_rd;
        logic data_wr;
        logic latch;
        logic busy;
        logic done;
        logic [15:0] jump_addr;
        logic int_busy;
        logic int_done;
        logic [7:0] rdata;
        logic hit;
    } mat_regs_t;

    mat_regs_t st;
    mat_regs_t next_st;

    // ----
    // timers and pointer steppers
    // ----
    logic ext_start;
    logic [8:0] ext_len;
    logic ext_last;
    logic int_start;
    logic [8:0] int_len;
    logic int_run;
    logic int_last;
    logic [15:0] ptr0_stepped;
    logic [15:0] ptr1_stepped;

    mat_wait_timer #(.W(9)) u_ext_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(ext_start),
        .len_i(ext_len),
        .run_o(),
        .last_o(ext_last)
    );

    mat_wait_timer #(.W(9)) u_int_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .start_i(int_start),
        .len_i(int_len),
        .run_o(int_run),
        .last_o(int_last)
    );

    mat_ptr_step u_step0 (
        .ptr_i(st.pointer0_pair),
        .dec_i(st.pointer0_decrement_bit),
        .ptr_o(ptr0_stepped)
    );

    mat_ptr_step u_step1 (
        .ptr_i(st.pointer1_pair),
        .dec_i(st.pointer1_decrement_bit),
        .ptr_o(ptr1_stepped)
    );

    // ----
    // derived widths
    // ----
    logic [2:0] code_wait_eff;
    logic [2:0] data_strobe_eff;
    logic [2:0] code_wr_eff;
    logic [15:0] sel_ptr;
    logic [7:0] sel_ext;
    logic mux_mode;

    // unused low settings are raised to the fastest legal value
    always_comb begin
        code_wait_eff = (st.code_wait_field < CODE_WAIT_MIN) ?
            CODE_WAIT_MIN : st.code_wait_field;
        data_strobe_eff = (st.data_strobe_field < DATA_STROBE_MIN) ?
            DATA_STROBE_MIN : st.data_strobe_field;
        code_wr_eff = (data_strobe_eff < CODE_WR_WAIT_MIN) ?
            CODE_WR_WAIT_MIN : data_strobe_eff;
        sel_ptr = st.select_bit ? st.pointer1_pair
                                : st.pointer0_pair;
        sel_ext = st.select_bit ? st.pointer1_extension
                                : st.pointer0_extension;
        mux_mode = (external_pin_mode_i == PIN_MODE_MUX1) ||
                   (external_pin_mode_i == PIN_MODE_MUX2);
    end

    // ----
    // next state
    // ----
    logic take;
    logic toggles;
    logic is_move;
    logic is_wr;

    always_comb begin
        next_st = st;
        ext_start = 1'b0;
        ext_len = 9'h000;
        int_start = 1'b0;
        int_len = 9'h000;
        next_st.done = 1'b0;
        next_st.int_done = 1'b0;
        take = op_valid_i && !st.busy;
        is_move = (op_code_i == OP_MOVE_PTR_RD) ||
                  (op_code_i == OP_MOVE_PTR_WR) ||
                  (op_code_i == OP_MOVE_IND_RD) ||
                  (op_code_i == OP_MOVE_IND_WR);
        is_wr = (op_code_i == OP_MOVE_PTR_WR) ||
                (op_code_i == OP_MOVE_IND_WR);
        toggles = (op_code_i == OP_PTR_INC) ||
                  (op_code_i == OP_PTR_LOAD) ||
                  (op_code_i == OP_TABLE_RD) ||
                  (op_code_i == OP_MOVE_PTR_RD) ||
                  (op_code_i == OP_MOVE_PTR_WR);

        // register writes; a same-cycle pointer operation overrides
        if (sfr_wr_i) begin
            case (sfr_addr_i)
                OFF_PTR0_LO: next_st.pointer0_pair[7:0] = sfr_wdata_i;
                OFF_PTR0_HI: next_st.pointer0_pair[15:8] = sfr_wdata_i;
                OFF_PTR1_LO: next_st.pointer1_pair[7:0] = sfr_wdata_i;
                OFF_PTR1_HI: next_st.pointer1_pair[15:8] = sfr_wdata_i;
                OFF_PTR_SEL: begin
                    next_st.select_bit = sfr_wdata_i[SEL_BIT];
                    next_st.toggle_enable_bit = sfr_wdata_i[TOGGLE_BIT];
                    next_st.pointer0_decrement_bit = sfr_wdata_i[DEC0_BIT];
                    next_st.pointer1_decrement_bit = sfr_wdata_i[DEC1_BIT];
                end
                OFF_STROBE_CTL: begin
                    next_st.strobe_ctl_upper = sfr_wdata_i[7:6];
                    next_st.data_strobe_field = sfr_wdata_i[2:0];
                end
                OFF_CODE_WAIT: next_st.code_wait_field = sfr_wdata_i[2:0];
                OFF_PTR0_EXT: next_st.pointer0_extension = sfr_wdata_i;
                OFF_PTR1_EXT: next_st.pointer1_extension = sfr_wdata_i;
                OFF_INT_WAIT: next_st.internal_wait_states = sfr_wdata_i;
                OFF_LATCH_DUR: next_st.latch_strobe_duration = sfr_wdata_i;
                OFF_IND_EXT: next_st.indirect_move_extension = sfr_wdata_i;
                default: begin
                end
            endcase
        end

        // register reads, answered one cycle later
        next_st.rdata = 8'h00;
        next_st.hit = 1'b0;
        if (sfr_rd_i) begin
            next_st.hit = 1'b1;
            case (sfr_addr_i)
                OFF_PTR0_LO: next_st.rdata = st.pointer0_pair[7:0];
                OFF_PTR0_HI: next_st.rdata = st.pointer0_pair[15:8];
                OFF_PTR1_LO: next_st.rdata = st.pointer1_pair[7:0];
                OFF_PTR1_HI: next_st.rdata = st.pointer1_pair[15:8];
                OFF_PTR_SEL: next_st.rdata = {st.pointer1_decrement_bit,
                    st.pointer0_decrement_bit, st.toggle_enable_bit,
                    4'h0, st.select_bit};
                OFF_STROBE_CTL: next_st.rdata = {st.strobe_ctl_upper,
                    3'h0, st.data_strobe_field};
                OFF_CODE_WAIT: next_st.rdata = {5'h00, st.code_wait_field};
                OFF_PTR0_EXT: next_st.rdata = st.pointer0_extension;
                OFF_PTR1_EXT: next_st.rdata = st.pointer1_extension;
                OFF_INT_WAIT: next_st.rdata = st.internal_wait_states;
                OFF_LATCH_DUR: next_st.rdata = st.latch_strobe_duration;
                OFF_IND_EXT: next_st.rdata = st.indirect_move_extension;
                default: next_st.hit = 1'b0;
            endcase
        end

        // pointer effects of an accepted operation
        if (take) begin
            if (op_code_i == OP_PTR_INC) begin
                if (st.select_bit) begin
                    next_st.pointer1_pair = ptr1_stepped;
                end else begin
                    next_st.pointer0_pair = ptr0_stepped;
                end
            end
            if (op_code_i == OP_PTR_LOAD) begin
                if (st.select_bit) begin
                    next_st.pointer1_pair = op_addr_i;
                end else begin
                    next_st.pointer0_pair = op_addr_i;
                end
            end
            if (toggles && st.toggle_enable_bit) begin
                next_st.select_bit = !st.select_bit;
            end
            if (op_code_i == OP_JUMP) begin
                next_st.jump_addr = sel_ptr + {8'h00, acc_i};
            end
        end

        // access sequencer
        case (st.seq)
            ST_IDLE: begin
                if (take && (op_code_i == OP_FETCH ||
                             op_code_i == OP_TABLE_RD || is_move)) begin
                    next_st.busy = 1'b1;
                    next_st.is_write = is_move && is_wr;
                    next_st.to_code = !is_move ||
                        (is_wr && program_write_enable_bit_i);
                    if (op_code_i == OP_FETCH) begin
                        next_st.addr = {8'h00, op_addr_i};
                    end else if (op_code_i == OP_TABLE_RD) begin
                        next_st.addr = {8'h00, sel_ptr + {8'h00, acc_i}};
                    end else if (op_code_i == OP_MOVE_PTR_RD ||
                                 op_code_i == OP_MOVE_PTR_WR) begin
                        next_st.addr = {sel_ext, sel_ptr};
                    end else begin
                        next_st.addr = {st.indirect_move_extension,
                            port2_i, index_i};
                    end
                    // strobe length chosen per access kind
                    if (!is_move) begin
                        next_st.width = {1'b0, code_wait_eff} + 4'h1;
                    end else if (is_wr && program_write_enable_bit_i) begin
                        next_st.width = {1'b0, code_wr_eff} + 4'h1;
                    end else begin
                        next_st.width = {1'b0, data_strobe_eff} + 4'h1;
                    end
                    if (is_move && !next_st.to_code && mux_mode) begin
                        ext_start = 1'b1;
                        ext_len = {1'b0, st.latch_strobe_duration}
                            + 9'h001;
                        next_st.seq = ST_LATCH;
                    end else begin
                        ext_start = 1'b1;
                        ext_len = {5'h00, next_st.width};
                        next_st.seq = ST_STROBE;
                    end
                end else if (take) begin
                    // register-only operations finish at once
                    next_st.done = 1'b1;
                end
            end
            ST_LATCH: begin
                if (ext_last) begin
                    ext_start = 1'b1;
                    ext_len = {5'h00, st.width};
                    next_st.seq = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (ext_last) begin
                    next_st.seq = ST_DONE;
                end
            end
            ST_DONE: begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
                next_st.seq = ST_IDLE;
            end
            default: begin
                next_st.busy = 1'b0;
                next_st.seq = ST_IDLE;
            end
        endcase

        // strobes registered from the next state so they track the timer
        next_st.latch = (next_st.seq == ST_LATCH);
        next_st.code_rd = (next_st.seq == ST_STROBE) &&
            next_st.to_code && !next_st.is_write;
        next_st.code_wr = (next_st.seq == ST_STROBE) &&
            next_st.to_code && next_st.is_write;
        next_st.data_rd = (next_st.seq == ST_STROBE) &&
            !next_st.to_code && !next_st.is_write;
        next_st.data_wr = (next_st.seq == ST_STROBE) &&
            !next_st.to_code && next_st.is_write;

        // internal memory accesses run independently of the pins
        if (int_req_i && !st.int_busy) begin
            int_start = 1'b1;
            case (int_tgt_i)
                TGT_RAM: int_len = {5'h00, RAM_EXTRA + {2'b00,
                    st.internal_wait_states[RAM_WAIT_LSB +: 2]}};
                TGT_NET: int_len = {5'h00, PERIPH_EXTRA + {1'b0,
                    st.internal_wait_states[NET_WAIT_LSB +: 3]}};
                default: int_len = {5'h00, PERIPH_EXTRA + {1'b0,
                    st.internal_wait_states[FLASH_WAIT_LSB +: 3]}};
            endcase
            next_st.int_busy = 1'b1;
        end else if (st.int_busy && int_last) begin
            next_st.int_busy = 1'b0;
            next_st.int_done = 1'b1;
        end else if (st.int_busy && !int_run) begin
            next_st.int_busy = 1'b0;
        end
    end

    // ----
    // registers
    // ----
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.pointer0_pair <= RST_PTR;
            st.pointer1_pair <= RST_PTR;
            st.select_bit <= RST_PTR_SEL[SEL_BIT];
            st.toggle_enable_bit <= RST_PTR_SEL[TOGGLE_BIT];
            st.pointer0_decrement_bit <= RST_PTR_SEL[DEC0_BIT];
            st.pointer1_decrement_bit <= RST_PTR_SEL[DEC1_BIT];
            st.strobe_ctl_upper <= RST_STROBE_CTL[7:6];
            st.data_strobe_field <= RST_STROBE_CTL[2:0];
            st.code_wait_field <= RST_CODE_WAIT;
            st.pointer0_extension <= RST_EXT;
            st.pointer1_extension <= RST_EXT;
            st.indirect_move_extension <= RST_EXT;
            st.internal_wait_states <= RST_INT_WAIT;
            st.latch_strobe_duration <= RST_LATCH_DUR;
            st.seq <= ST_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ----
    // outputs, all straight from flops
    // ----
    assign sfr_rdata_o = st.rdata;
    assign sfr_hit_o = st.hit;
    assign op_busy_o = st.busy;
    assign op_done_o = st.done;
    assign jump_addr_o = st.jump_addr;
    assign mem_addr_o = st.addr;
    assign code_rd_o = st.code_rd;
    assign code_wr_o = st.code_wr;
    assign data_rd_o = st.data_rd;
    assign data_wr_o = st.data_wr;
    assign latch_strobe_o = st.latch;
    assign int_busy_o = st.int_busy;
    assign int_done_o = st.int_done;

endmodule

// ===== mat_sfr_timing_asserts.sv
`timescale 1ns/1ps
// ----
// timing checks at the block ports
// ----
module mat_sfr_timing_asserts (
    // clock, reset, register port
    input wire logic clk_sys_i, resetn_i, sfr_rd_i, sfr_hit_o,
    // pin mode and strobes
    input wire logic [2:0] external_pin_mode_i,
    input wire logic op_busy_o, op_done_o, code_rd_o, code_wr_o,
    input wire logic data_rd_o, data_wr_o, latch_strobe_o,
    // internal access
    input wire logic int_busy_o, int_done_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    a_code_rd_len: assert property ($rose(code_rd_o)
        |-> code_rd_o[*5] ##[1:4] !code_rd_o) else $error("code read width");
    a_data_rd_len: assert property ($rose(data_rd_o)
        |-> data_rd_o[*3] ##[1:6] !data_rd_o) else $error("data read width");
    a_code_wr_len: assert property ($rose(code_wr_o)
        |-> code_wr_o[*5] ##[1:4] !code_wr_o) else $error("code write width");
    a_latch_mux_mode: assert property (latch_strobe_o
        |-> external_pin_mode_i inside {3'h1, 3'h3}) else $error("latch mode");
    a_latch_then_data: assert property ($fell(latch_strobe_o)
        |-> data_rd_o || data_wr_o) else $error("latch not before strobe");
    a_done_pulse: assert property (op_done_o
        |-> !op_busy_o ##1 !op_done_o) else $error("done pulse");
    a_int_len: assert property ($rose(int_busy_o)
        |-> int_busy_o[*2] ##[1:9] (int_done_o && !int_busy_o))
        else $error("internal access length");
    a_read_hit: assert property (sfr_hit_o
        |-> $past(sfr_rd_i)) else $error("hit without read");
endmodule
bind mat_sfr_timing mat_sfr_timing_asserts chk_u (.clk_sys_i, .resetn_i,
    .sfr_rd_i, .sfr_hit_o, .external_pin_mode_i, .op_busy_o, .op_done_o,
    .code_rd_o, .code_wr_o, .data_rd_o, .data_wr_o, .latch_strobe_o,
    .int_busy_o, .int_done_o);

// ===== mat_mem_model.sv
`timescale 1ns/1ps
// ----
// far-side memory: length of each access it is given
// ----
module mat_mem_model (
    input wire logic clk_sys_i,
    input wire logic strobe_i,
    output int width_o
);
    int cnt = 0;
    // length known only once the access ends
    always @(posedge clk_sys_i) begin
        if (strobe_i) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            width_o <= cnt;
            cnt <= 0;
        end
    end
endmodule

// ===== test_mat_sfr_timing.sv
`timescale 1ns/1ps
module test_mat_sfr_timing;
    import mat_pkg::*;
    logic clk_sys_i = 0, resetn_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, s, wc;
    logic op_valid_i = 0, int_req_i = 0, program_write_enable_bit_i = 0;
    logic [7:0] sfr_addr_i = 0, sfr_wdata_i = 0, acc_i = 0, index_i = 0;
    logic [7:0] port2_i = 0, sfr_rdata_o, o;
    logic [15:0] op_addr_i = 0, jump_addr_o, p;
    logic [2:0] external_pin_mode_i = 3'h1;
    mat_op_t op_code_i = OP_FETCH;
    mat_tgt_t int_tgt_i = TGT_RAM;
    logic sfr_hit_o, op_busy_o, op_done_o, code_rd_o, code_wr_o, data_rd_o;
    logic data_wr_o, latch_strobe_o, int_busy_o, int_done_o;
    logic [23:0] mem_addr_o, ea, e, ns;
    logic [7:0] regs [logic [7:0]];
    logic [7:0] offs [8] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h93, 8'h95,
        8'h9C, 8'hEA};
    int errors = 0, samples_checked = 0, seed = 32'h0aa6e108, t, w, wint;
    mat_sfr_timing dut_u (.clk_sys_i, .resetn_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sfr_hit_o, .op_valid_i,
        .op_code_i, .op_addr_i, .acc_i, .index_i, .port2_i, .op_busy_o,
        .program_write_enable_bit_i, .external_pin_mode_i, .op_done_o,
        .jump_addr_o, .mem_addr_o, .code_rd_o, .code_wr_o, .data_rd_o,
        .data_wr_o, .latch_strobe_o, .int_req_i, .int_tgt_i, .int_busy_o,
        .int_done_o);
    mat_mem_model mem_u (.clk_sys_i, .strobe_i(int_busy_o), .width_o(wint));
    always #25 clk_sys_i = ~clk_sys_i;
    task automatic chk(input string n, input logic [23:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk_sys_i);
        sfr_wr_i <= 1'b1;
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        if (regs.exists(a)) regs[a] = d;
        @(posedge clk_sys_i);
        sfr_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_i);
        sfr_rd_i <= 1'b1;
        sfr_addr_i <= a;
        @(posedge clk_sys_i);
        sfr_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("rdata", sfr_rdata_o, regs.exists(a) ? regs[a] : 8'h00);
        chk("hit", sfr_hit_o, regs.exists(a));
    endtask
    // bounded wait; strobe cycles summed per nibble on the way
    task automatic waitd(input logic which);
        ns = 0;
        for (t = 0; t < 400 && (which ? int_done_o : op_done_o) !== 1'b1;
            t++) begin
            @(negedge clk_sys_i);
            ns += {4'(latch_strobe_o), 4'(code_rd_o), 4'(code_wr_o),
                4'(data_rd_o), 4'(data_wr_o)};
        end
        if (t == 400) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic op(input mat_op_t c);
        s = regs[8'h86][0];
        o = s ? 8'h84 : 8'h82;
        p = {regs[o + 8'h01], regs[o]};
        wc = c == OP_MOVE_PTR_WR || c == OP_MOVE_IND_WR;
        ea = c >= OP_MOVE_IND_RD ? {regs[8'hEA], port2_i, index_i}
            : c == OP_FETCH ? {8'h00, op_addr_i} : {regs[s ? 8'h95 : 8'h93], p};
        w = c == OP_FETCH || c == OP_TABLE_RD ? regs[8'h92][2:0] + 1
            : program_write_enable_bit_i && wc && regs[8'h8E][2:0] < 4 ? 5
            : regs[8'h8E][2:0] + 1;
        e = c == OP_FETCH || c == OP_TABLE_RD ? w << 12 : c < OP_MOVE_PTR_RD ? 0
            : program_write_enable_bit_i && wc ? w << 8 : wc ? w : w << 4;
        if (c >= OP_MOVE_PTR_RD && !(program_write_enable_bit_i && wc)
            && !external_pin_mode_i[2]) e += (regs[8'h9F] + 1) << 16;
        // pointer step and select toggle land at the take
        if (c == OP_PTR_INC) p = regs[8'h86][6 + s] ? p - 1 : p + 1;
        if (c == OP_PTR_LOAD) p = op_addr_i;
        regs[o] = p[7:0];
        regs[o + 8'h01] = p[15:8];
        if (regs[8'h86][5] && c inside {OP_PTR_INC, OP_PTR_LOAD, OP_TABLE_RD,
            OP_MOVE_PTR_RD, OP_MOVE_PTR_WR}) regs[8'h86][0] = !s;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b1;
        op_code_i <= c;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b0;
        waitd(1'b0);
        chk("strobes", ns, e);
        if (c >= OP_MOVE_PTR_RD) chk("addr", mem_addr_o, ea);
        if (c == OP_FETCH) chk("fetch addr", mem_addr_o, ea);
        if (c == OP_JUMP) chk("jump", jump_addr_o, 16'(p + acc_i));
    endtask
    task automatic ireq(input mat_tgt_t g);
        @(posedge clk_sys_i);
        int_req_i <= 1'b1;
        int_tgt_i <= g;
        @(posedge clk_sys_i);
        int_req_i <= 1'b0;
        waitd(1'b1);
        // the model posts a width one edge after the done pulse
        @(negedge clk_sys_i);
        @(negedge clk_sys_i);
        chk("int", 24'(wint), g == TGT_RAM ? regs[8'h9C][7:6] + 2
            : (g == TGT_NET ? regs[8'h9C][5:3] : regs[8'h9C][2:0]) + 3);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        regs = '{8'h82: 0, 8'h83: 0, 8'h84: 0, 8'h85: 0, 8'h86: 0,
            8'h8E: 7, 8'h92: 7, 8'h93: 0, 8'h95: 0, 8'h9C: 8'hFF,
            8'h9F: 8'hFF, 8'hEA: 0};
        repeat (16) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        foreach (regs[a]) rd(a);
        $display("reset values done");
        for (int r = 0; r < 8; r++) begin
            @(posedge clk_sys_i);
            {acc_i, index_i, port2_i, op_addr_i} <= 40'({$random(seed),
                $random(seed)});
            program_write_enable_bit_i <= r[0];
            external_pin_mode_i <= {r[2:1], 1'b1};
            wr(8'h8E, 8'(2 + {$random(seed)} % 6));
            wr(8'h92, 8'(4 + {$random(seed)} % 4));
            wr(8'h9F, 8'({$random(seed)} % 8));
            wr(8'h86, 8'($random(seed)) & 8'hE1);
            foreach (offs[k]) wr(offs[k], 8'($random(seed)));
            for (int i = 0; i < 9; i++) op(mat_op_t'(i));
            for (int i = 0; i < 3; i++) ireq(mat_tgt_t'(i));
            wr(8'h80, 8'h5A);
            rd(8'h80);
            foreach (regs[a]) rd(a);
            $display("round %0d done", r);
        end
        tally_and_finish();
    end
endmodule
